// *** rtl/vhap_pkg.sv ***
// shared port addresses, indices, field positions and codes
package vhap_pkg;
   // i/o port addresses
   localparam logic [15:0] P_ATTR_IDX = 16'h03C0;
   localparam logic [15:0] P_ATTR_RD = 16'h03C1;
   localparam logic [15:0] P_MISC_WR_ST1 = 16'h03C2;
   localparam logic [15:0] P_ENABLE = 16'h03C3;
   localparam logic [15:0] P_SEQ_IDX = 16'h03C4;
   localparam logic [15:0] P_SEQ_DAT = 16'h03C5;
   localparam logic [15:0] P_PIX_MASK = 16'h03C6;
   localparam logic [15:0] P_PAL_ADDR_ALT = 16'h03C7;
   localparam logic [15:0] P_PAL_ADDR = 16'h03C8;
   localparam logic [15:0] P_PAL_DATA = 16'h03C9;
   localparam logic [15:0] P_FEAT_RD = 16'h03CA;
   localparam logic [15:0] P_MISC_RD = 16'h03CC;
   localparam logic [15:0] P_GFX_IDX = 16'h03CE;
   localparam logic [15:0] P_GFX_DAT = 16'h03CF;
   localparam logic [15:0] P_CRT_IDX_M = 16'h03B4;
   localparam logic [15:0] P_CRT_DAT_M = 16'h03B5;
   localparam logic [15:0] P_ST2_M = 16'h03BA;
   localparam logic [15:0] P_CRT_IDX_C = 16'h03D4;
   localparam logic [15:0] P_CRT_DAT_C = 16'h03D5;
   localparam logic [15:0] P_ST2_C = 16'h03DA;
   // indexed register numbers
   localparam logic [7:0] SEQ_MAP_MASK = 8'h02;
   localparam logic [7:0] SEQ_MEM_MODE = 8'h04;
   localparam logic [7:0] GFX_CMP = 8'h02;
   localparam logic [7:0] GFX_RMAP = 8'h04;
   localparam logic [7:0] GFX_MODE = 8'h05;
   localparam logic [7:0] GFX_MISC = 8'h06;
   localparam logic [7:0] GFX_DC = 8'h07;
   // field positions
   localparam int MISC_EMU_BIT = 0;
   localparam int MISC_RAM_BIT = 1;
   localparam int MISC_PAGE_BIT = 5;
   localparam int GFX_RTYPE_BIT = 3;
   localparam int GFX_OE_BIT = 4;
   localparam int GFX_MAP_LSB = 2;
   localparam int SEQ_CHAIN4_BIT = 3;
   localparam int ATTR_IDX_W = 6;
   localparam int PAL_W = 6;
   // memory windows
   localparam logic [1:0] WIN_A128 = 2'h0;
   localparam logic [1:0] WIN_A64 = 2'h1;
   localparam logic [1:0] WIN_B0 = 2'h2;
   localparam logic [1:0] WIN_B8 = 2'h3;
   localparam logic [2:0] TOP_A128 = 3'h5;
   localparam logic [3:0] TOP_A64 = 4'hA;
   localparam logic [4:0] TOP_B0 = 5'h16;
   localparam logic [4:0] TOP_B8 = 5'h17;
   // odd/even plane pairs
   localparam logic [3:0] EVEN_PLANES = 4'h5;
   localparam logic [3:0] ODD_PLANES = 4'hA;
   // values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] UNMAPPED = 8'hFF;
   localparam logic [1:0] DAC_ST_RD = 2'h3;
   localparam logic [1:0] DAC_ST_WR = 2'h0;
   typedef enum logic [1:0] {
      PAL_RED = 2'b00,
      PAL_GREEN = 2'b01,
      PAL_BLUE = 2'b11
   } vhap_pal_st_t;
endpackage : vhap_pkg

// *** rtl/vhap_plane_store.sv ***
// four video planes with the processor data latches
`timescale 1ns/1ns
module vhap_plane_store #(
   parameter int AW = 16
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] wr_mask,
   input wire logic [AW-1:0] wr_off,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_off,
   output logic [31:0] latch,
   output logic latch_valid
);
   typedef struct packed {
      logic [31:0] latch;
      logic valid;
   } vhap_ps_state_t;
   vhap_ps_state_t s_ff, nxt_s;
   logic [31:0] rd_word;

   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_plane
         logic [7:0] mem [2**AW];
         always_ff @(posedge ref_clk) begin
            if (wr_mask[p]) begin
               mem[wr_off] <= wr_data;
            end
         end
         assign rd_word[8*p +: 8] = mem[rd_off];
      end
   endgenerate

   always_comb begin
      nxt_s = s_ff;
      nxt_s.valid = rd_en;
      if (rd_en) begin
         nxt_s.latch = rd_word;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign latch = s_ff.latch;
   assign latch_valid = s_ff.valid;
endmodule : vhap_plane_store

// *** rtl/vhap_read_sel.sv ***
// plane byte select or colour compare on the latched planes
`timescale 1ns/1ns
module vhap_read_sel (
   input wire logic [31:0] latch,
   input wire logic read_type,
   input wire logic [1:0] plane,
   input wire logic [3:0] cmp,
   input wire logic [3:0] care,
   output logic [7:0] data
);
   logic [7:0] match;
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         logic [3:0] pix;
         assign pix = {latch[24+b], latch[16+b], latch[8+b], latch[b]};
         assign match[b] = ~|((pix ^ cmp) & care);
      end
   endgenerate
   assign data = read_type ? match : latch[8*plane +: 8];
endmodule : vhap_read_sel

// *** rtl/vhap_top.sv ***
// video host access port: memory path and register port decode
// What this block does
// - write planes from address and plane mask
// - read type 0 returns selected plane byte
// - read type 1 returns colour compare byte
// - all registers readable except latches, toggle
// - status two at 03BA or 03DA
// - status one read at 03C2
// - attribute index/data at 03C0, read 03C1
// - timing index/data at 03B4/5 or 03D4/5
// - palette address written 03C7/03C8, read 03C8
// - palette colour data port at 03C9
// - mode 7 characters even plane 0
// - leftmost pixel in msb of planes
// - misc output written 03C2, read 03CC
// - misc bit 0 moves timing ports
`timescale 1ns/1ns
module vhap_top #(
   parameter int PLANE_AW = 16,
   parameter int CRT_N = 25,
   parameter int SEQ_N = 5,
   parameter int GFX_N = 9,
   parameter int ATTR_N = 21
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   input wire logic [19:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic mem_rvalid,
   input wire logic crt_irq,
   input wire logic switch_sense,
   input wire logic vretrace,
   input wire logic disp_inactive,
   input wire logic [1:0] diag,
   output logic [7:0] misc_out,
   output logic [7:0] pixel_mask_out
);
   if (PLANE_AW != 16 || CRT_N < 1 || CRT_N > 256 || SEQ_N <= 4
       || GFX_N <= 7 || ATTR_N < 1 || ATTR_N > 32) begin : g_chk
      $error("vhap_top: unsupported parameter values");
   end

   localparam int ATTR_IDX_W = vhap_pkg::ATTR_IDX_W;
   localparam int PAL_W = vhap_pkg::PAL_W;

   typedef struct packed {
      logic [7:0] misc;
      logic [7:0] feat;
      logic [7:0] ena;
      logic [7:0] pmask;
      logic [7:0] seq_idx;
      logic [7:0] gfx_idx;
      logic [7:0] crt_idx;
      logic [ATTR_IDX_W-1:0] attr_idx;
      logic attr_flip;
      logic [SEQ_N-1:0][7:0] seq;
      logic [GFX_N-1:0][7:0] gfx;
      logic [CRT_N-1:0][7:0] crt;
      logic [ATTR_N-1:0][7:0] attr;
      logic [7:0] pal_addr;
      logic dac_rd;
      vhap_pkg::vhap_pal_st_t pal_st;
      logic [PAL_W-1:0] pal_r;
      logic [PAL_W-1:0] pal_g;
      logic [7:0] io_rdata;
      logic io_rvalid;
      logic rd_hit;
      logic [1:0] rd_plane;
      logic [7:0] mem_rdata;
      logic mem_rvalid;
   } vhap_state_t;

   vhap_state_t s_ff, nxt_s;
   logic [3*PAL_W-1:0] pal_mem [256];
   logic pal_we;
   logic [15:0] crt_idx_port, crt_dat_port, st2_port;
   logic [7:0] rd_val, sel_byte;
   logic [7:0] map_mask, mem_mode, gmode, gmisc;
   logic win_hit, chain4, odd_even;
   logic [15:0] win_off, plane_off;
   logic [3:0] wr_mask;
   logic [1:0] rd_plane;
   logic [31:0] latch;
   logic latch_valid;

   assign crt_idx_port = s_ff.misc[vhap_pkg::MISC_EMU_BIT] ?
                         vhap_pkg::P_CRT_IDX_C : vhap_pkg::P_CRT_IDX_M;
   assign crt_dat_port = s_ff.misc[vhap_pkg::MISC_EMU_BIT] ?
                         vhap_pkg::P_CRT_DAT_C : vhap_pkg::P_CRT_DAT_M;
   // status two at one port only
   assign st2_port = s_ff.misc[vhap_pkg::MISC_EMU_BIT] ?
                     vhap_pkg::P_ST2_C : vhap_pkg::P_ST2_M;

   assign map_mask = s_ff.seq[vhap_pkg::SEQ_MAP_MASK];
   assign mem_mode = s_ff.seq[vhap_pkg::SEQ_MEM_MODE];
   assign gmode = s_ff.gfx[vhap_pkg::GFX_MODE];
   assign gmisc = s_ff.gfx[vhap_pkg::GFX_MISC];
   assign chain4 = mem_mode[vhap_pkg::SEQ_CHAIN4_BIT];
   assign odd_even = gmode[vhap_pkg::GFX_OE_BIT];

   // window decode from memory map select
   always_comb begin
      win_hit = 1'b0;
      win_off = {1'b0, mem_addr[14:0]};
      case (gmisc[vhap_pkg::GFX_MAP_LSB +: 2])
         vhap_pkg::WIN_A128: begin
            win_hit = mem_addr[19:17] == vhap_pkg::TOP_A128;
            win_off = mem_addr[15:0];
         end
         vhap_pkg::WIN_A64: begin
            win_hit = mem_addr[19:16] == vhap_pkg::TOP_A64;
            win_off = mem_addr[15:0];
         end
         vhap_pkg::WIN_B0: begin
            win_hit = mem_addr[19:15] == vhap_pkg::TOP_B0;
         end
         default: begin
            win_hit = mem_addr[19:15] == vhap_pkg::TOP_B8;
         end
      endcase
      win_hit = win_hit & s_ff.misc[vhap_pkg::MISC_RAM_BIT];
   end

   // plane choice per addressing scheme
   always_comb begin
      plane_off = win_off;
      wr_mask = '0;
      rd_plane = s_ff.gfx[vhap_pkg::GFX_RMAP][1:0];
      if (chain4) begin
         plane_off = {win_off[15:2], 2'b00};
         rd_plane = win_off[1:0];
         wr_mask = map_mask[3:0] & (4'h1 << win_off[1:0]);
      end else if (odd_even) begin
         // even to planes 0 and 2, odd to 1 and 3
         plane_off = {win_off[15:1], s_ff.misc[vhap_pkg::MISC_PAGE_BIT]};
         rd_plane = {s_ff.gfx[vhap_pkg::GFX_RMAP][1], win_off[0]};
         wr_mask = map_mask[3:0] & (win_off[0] ? vhap_pkg::ODD_PLANES :
                                    vhap_pkg::EVEN_PLANES);
      end else begin
         wr_mask = map_mask[3:0];
      end
      wr_mask = wr_mask & {4{mem_wr & win_hit}};
   end

   vhap_plane_store #(
      .AW(PLANE_AW)
   ) i_vhap_plane_store (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_mask(wr_mask),
      .wr_off(plane_off),
      .wr_data(mem_wdata),
      .rd_en(mem_rd),
      .rd_off(plane_off),
      .latch(latch),
      .latch_valid(latch_valid)
   );

   vhap_read_sel i_vhap_read_sel (
      .latch(latch),
      .read_type(gmode[vhap_pkg::GFX_RTYPE_BIT]),
      .plane(s_ff.rd_plane),
      .cmp(s_ff.gfx[vhap_pkg::GFX_CMP][3:0]),
      .care(s_ff.gfx[vhap_pkg::GFX_DC][3:0]),
      .data(sel_byte)
   );

   // complete colour entry written on blue
   assign pal_we = io_wr && io_addr == vhap_pkg::P_PAL_DATA &&
                   s_ff.pal_st == vhap_pkg::PAL_BLUE;
   always_ff @(posedge ref_clk) begin
      if (pal_we) begin
         pal_mem[s_ff.pal_addr] <= {s_ff.pal_r, s_ff.pal_g,
                                    io_wdata[PAL_W-1:0]};
      end
   end

   always_comb begin
      rd_val = vhap_pkg::UNMAPPED;
      if (io_addr == crt_idx_port) begin
         rd_val = s_ff.crt_idx;
      end else if (io_addr == crt_dat_port) begin
         rd_val = s_ff.crt_idx < CRT_N ? s_ff.crt[s_ff.crt_idx] : '0;
      end else if (io_addr == st2_port) begin
         rd_val = {2'b00, diag, vretrace, 2'b00, disp_inactive};
      end else begin
         case (io_addr)
            vhap_pkg::P_ATTR_IDX: begin
               rd_val = {2'b00, s_ff.attr_idx};
            end
            vhap_pkg::P_ATTR_RD: begin
               rd_val = s_ff.attr_idx[4:0] < ATTR_N ?
                        s_ff.attr[s_ff.attr_idx[4:0]] : '0;
            end
            vhap_pkg::P_MISC_WR_ST1: begin
               rd_val = {crt_irq, 2'b00, switch_sense, 4'h0};
            end
            vhap_pkg::P_ENABLE: rd_val = s_ff.ena;
            vhap_pkg::P_SEQ_IDX: rd_val = s_ff.seq_idx;
            vhap_pkg::P_SEQ_DAT: begin
               rd_val = s_ff.seq_idx < SEQ_N ? s_ff.seq[s_ff.seq_idx] : '0;
            end
            vhap_pkg::P_PIX_MASK: rd_val = s_ff.pmask;
            vhap_pkg::P_PAL_ADDR_ALT: begin
               rd_val = {6'h00, s_ff.dac_rd ? vhap_pkg::DAC_ST_RD :
                                              vhap_pkg::DAC_ST_WR};
            end
            vhap_pkg::P_PAL_ADDR: rd_val = s_ff.pal_addr;
            vhap_pkg::P_PAL_DATA: begin
               case (s_ff.pal_st)
                  vhap_pkg::PAL_RED: begin
                     rd_val = {2'b00, pal_mem[s_ff.pal_addr][17:12]};
                  end
                  vhap_pkg::PAL_GREEN: begin
                     rd_val = {2'b00, pal_mem[s_ff.pal_addr][11:6]};
                  end
                  default: begin
                     rd_val = {2'b00, pal_mem[s_ff.pal_addr][5:0]};
                  end
               endcase
            end
            vhap_pkg::P_FEAT_RD: rd_val = s_ff.feat;
            vhap_pkg::P_MISC_RD: rd_val = s_ff.misc;
            vhap_pkg::P_GFX_IDX: rd_val = s_ff.gfx_idx;
            vhap_pkg::P_GFX_DAT: begin
               rd_val = s_ff.gfx_idx < GFX_N ? s_ff.gfx[s_ff.gfx_idx] : '0;
            end
            default: rd_val = vhap_pkg::UNMAPPED;
         endcase
      end
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.io_rvalid = io_rd;
      nxt_s.mem_rvalid = latch_valid;
      if (io_rd) begin
         nxt_s.io_rdata = rd_val;
         if (io_addr == st2_port) begin
            nxt_s.attr_flip = 1'b0;
         end
         if (io_addr == vhap_pkg::P_PAL_DATA) begin
            case (s_ff.pal_st)
               vhap_pkg::PAL_RED: nxt_s.pal_st = vhap_pkg::PAL_GREEN;
               vhap_pkg::PAL_GREEN: nxt_s.pal_st = vhap_pkg::PAL_BLUE;
               default: begin
                  nxt_s.pal_st = vhap_pkg::PAL_RED;
                  nxt_s.pal_addr = s_ff.pal_addr + 8'h01;
               end
            endcase
         end
      end
      if (io_wr) begin
         if (io_addr == crt_idx_port) begin
            nxt_s.crt_idx = io_wdata;
         end else if (io_addr == crt_dat_port) begin
            if (s_ff.crt_idx < CRT_N) begin
               nxt_s.crt[s_ff.crt_idx] = io_wdata;
            end
         end else if (io_addr == st2_port) begin
            nxt_s.feat = io_wdata;
         end else begin
            case (io_addr)
               vhap_pkg::P_ATTR_IDX: begin
                  if (!s_ff.attr_flip) begin
                     nxt_s.attr_idx = io_wdata[ATTR_IDX_W-1:0];
                  end else if (s_ff.attr_idx[4:0] < ATTR_N) begin
                     nxt_s.attr[s_ff.attr_idx[4:0]] = io_wdata;
                  end
                  nxt_s.attr_flip = ~s_ff.attr_flip;
               end
               vhap_pkg::P_MISC_WR_ST1: nxt_s.misc = io_wdata;
               vhap_pkg::P_ENABLE: nxt_s.ena = io_wdata;
               vhap_pkg::P_SEQ_IDX: nxt_s.seq_idx = io_wdata;
               vhap_pkg::P_SEQ_DAT: begin
                  if (s_ff.seq_idx < SEQ_N) begin
                     nxt_s.seq[s_ff.seq_idx] = io_wdata;
                  end
               end
               vhap_pkg::P_PIX_MASK: nxt_s.pmask = io_wdata;
               vhap_pkg::P_PAL_ADDR_ALT, vhap_pkg::P_PAL_ADDR: begin
                  nxt_s.pal_addr = io_wdata;
                  nxt_s.pal_st = vhap_pkg::PAL_RED;
                  nxt_s.dac_rd = io_addr == vhap_pkg::P_PAL_ADDR_ALT;
               end
               vhap_pkg::P_PAL_DATA: begin
                  case (s_ff.pal_st)
                     vhap_pkg::PAL_RED: begin
                        nxt_s.pal_r = io_wdata[PAL_W-1:0];
                        nxt_s.pal_st = vhap_pkg::PAL_GREEN;
                     end
                     vhap_pkg::PAL_GREEN: begin
                        nxt_s.pal_g = io_wdata[PAL_W-1:0];
                        nxt_s.pal_st = vhap_pkg::PAL_BLUE;
                     end
                     default: begin
                        nxt_s.pal_st = vhap_pkg::PAL_RED;
                        nxt_s.pal_addr = s_ff.pal_addr + 8'h01;
                     end
                  endcase
               end
               vhap_pkg::P_GFX_IDX: nxt_s.gfx_idx = io_wdata;
               vhap_pkg::P_GFX_DAT: begin
                  if (s_ff.gfx_idx < GFX_N) begin
                     nxt_s.gfx[s_ff.gfx_idx] = io_wdata;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // memory read pipeline: plane then selected byte
      if (mem_rd) begin
         nxt_s.rd_hit = win_hit;
         nxt_s.rd_plane = rd_plane;
      end
      if (latch_valid) begin
         nxt_s.mem_rdata = s_ff.rd_hit ? sel_byte : vhap_pkg::UNMAPPED;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign io_rdata = s_ff.io_rdata;
   assign io_rvalid = s_ff.io_rvalid;
   assign mem_rdata = s_ff.mem_rdata;
   assign mem_rvalid = s_ff.mem_rvalid;
   assign misc_out = s_ff.misc;
   assign pixel_mask_out = s_ff.pmask;
endmodule : vhap_top

// *** tb/vhap_checker.sv ***
// assertions on the host port of the video access block
`timescale 1ns/1ns
module vhap_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid,
   input wire logic mem_rd,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_rvalid,
   input wire logic crt_irq,
   input wire logic switch_sense,
   input wire logic [7:0] misc_out,
   input wire logic [7:0] pixel_mask_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   rd_answer_a: assert property (io_rd |=> io_rvalid)
      else $error("io read not answered");
   rd_lone_a: assert property (io_rvalid |-> $past(io_rd))
      else $error("io answer without read");
   mem_answer_a: assert property (mem_rd |-> ##2 mem_rvalid)
      else $error("memory read not answered");
   mem_lone_a: assert property (mem_rvalid |-> $past(mem_rd, 2))
      else $error("memory answer without read");
   mem_off_a: assert property (mem_rd && !misc_out[1]
      |-> ##2 mem_rdata == 8'hFF)
      else $error("memory answered while disabled");
   misc_write_a: assert property (io_wr
      && io_addr == vhap_pkg::P_MISC_WR_ST1 |=> misc_out == $past(io_wdata))
      else $error("misc write lost");
   misc_read_a: assert property (io_rd && !io_wr
      && io_addr == vhap_pkg::P_MISC_RD |=> io_rdata == misc_out)
      else $error("misc readback wrong");
   st1_read_a: assert property (io_rd
      && io_addr == vhap_pkg::P_MISC_WR_ST1
      |=> io_rdata == {$past(crt_irq), 2'b00, $past(switch_sense), 4'h0})
      else $error("status one wrong");
   st2_wrong_a: assert property (io_rd && io_addr ==
      (misc_out[0] ? vhap_pkg::P_ST2_M : vhap_pkg::P_ST2_C)
      |=> io_rdata == 8'hFF)
      else $error("status two at both ports");
   crt_wrong_a: assert property (io_rd && io_addr ==
      (misc_out[0] ? vhap_pkg::P_CRT_DAT_M : vhap_pkg::P_CRT_DAT_C)
      |=> io_rdata == 8'hFF)
      else $error("timing port in wrong emulation");
   pix_hold_a: assert property (!(io_wr
      && io_addr == vhap_pkg::P_PIX_MASK) |=> $stable(pixel_mask_out))
      else $error("pixel mask changed");
   cover property (mem_rvalid && misc_out[1]);
   cover property (io_rd && io_addr == vhap_pkg::P_ST2_C);
   cover property (io_wr && io_addr == vhap_pkg::P_PAL_DATA);
endmodule : vhap_checker
bind vhap_top vhap_checker i_vhap_checker (.ref_clk(ref_clk),
   .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
   .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
   .crt_irq(crt_irq), .switch_sense(switch_sense), .misc_out(misc_out),
   .pixel_mask_out(pixel_mask_out));

// *** tb/vhap_host_model.sv ***
// processor bus model issuing i/o and memory strobes
`timescale 1ns/1ns
module vhap_host_model (
   input wire logic ref_clk,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   output logic [19:0] mem_addr,
   output logic mem_wr,
   output logic mem_rd,
   output logic [7:0] mem_wdata
);
   initial begin
      {io_addr, io_wr, io_rd, io_wdata} = '0;
      {mem_addr, mem_wr, mem_rd, mem_wdata} = '0;
   end
   task automatic io_cycle(input logic w, input logic [15:0] a,
      input logic [7:0] d);
      @(negedge ref_clk);
      if (w && a == vhap_pkg::P_PIX_MASK) return;
      io_addr <= a;
      io_wdata <= d;
      io_wr <= w;
      io_rd <= !w;
      @(negedge ref_clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask : io_cycle
   task automatic mem_cycle(input logic w, input logic [19:0] a,
      input logic [7:0] d);
      @(negedge ref_clk);
      mem_addr <= a;
      mem_wdata <= d;
      mem_wr <= w;
      mem_rd <= !w;
      @(negedge ref_clk);
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      mem_addr <= ~a;
      mem_wdata <= ~d;
   endtask : mem_cycle
endmodule : vhap_host_model

// *** tb/test_video_host_access_port.sv ***
// self-checking bench for the video host access port
`timescale 1ns/1ns
module test_video_host_access_port;
   logic ref_clk, reset_n, io_wr, io_rd, io_rvalid, mem_wr, mem_rd;
   logic mem_rvalid, crt_irq, switch_sense, vretrace, disp_inactive;
   logic [15:0] io_addr;
   logic [19:0] mem_addr;
   logic [7:0] io_wdata, io_rdata, mem_wdata, mem_rdata, misc_out;
   logic [7:0] pixel_mask_out;
   logic [1:0] diag;
   logic [15:0] io_q[$], mem_q[$];
   int mismatches = 0, cmp_count = 0, cycles = 0;
   vhap_top i_vhap_top (.ref_clk(ref_clk), .reset_n(reset_n),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .io_rvalid(io_rvalid), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .crt_irq(crt_irq),
      .switch_sense(switch_sense), .vretrace(vretrace),
      .disp_inactive(disp_inactive), .diag(diag), .misc_out(misc_out),
      .pixel_mask_out(pixel_mask_out));
   vhap_host_model i_vhap_host_model (.ref_clk(ref_clk),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_wdata(mem_wdata));
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_vhap_host_model.io_cycle(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e,
      input logic [7:0] m);
      io_q.push_back({e, m});
      i_vhap_host_model.io_cycle(1'b0, a, 8'h00);
   endtask : rd
   task automatic idx(input logic [15:0] a, input logic [7:0] i,
      input logic [7:0] d);
      wr(a, i);
      wr(a + 16'h0001, d);
   endtask : idx
   task automatic mrd(input logic [19:0] a, input logic [7:0] e);
      mem_q.push_back({e, 8'hFF});
      i_vhap_host_model.mem_cycle(1'b0, a, 8'h00);
   endtask : mrd
   task automatic check(input logic [15:0] n, input logic [7:0] got);
      cmp_count++;
      if ((got & n[7:0]) !== (n[15:8] & n[7:0])) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got & n[7:0],
            n[15:8] & n[7:0]);
      end
   endtask : check
   task automatic wrap_up;
      if (io_q.size() != 0 || mem_q.size() != 0) mismatches++;
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   always @(negedge ref_clk) begin
      if (io_rvalid === 1'b1) check(io_q.pop_front(), io_rdata);
      if (mem_rvalid === 1'b1) check(mem_q.pop_front(), mem_rdata);
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      logic [7:0] d[4];
      logic [7:0] e, i, c, k;
      logic [15:0] b, o;
      logic [19:0] a;
      reset_n = 1'b0;
      {crt_irq, switch_sense, vretrace, disp_inactive, diag} = '0;
      void'($urandom(32'h4844016C));
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      rd(vhap_pkg::P_MISC_RD, 8'h00, 8'hFF);
      rd(vhap_pkg::P_PIX_MASK, 8'h00, 8'hFF);
      mrd(20'hA0000, 8'hFF);
      {crt_irq, switch_sense, vretrace, disp_inactive, diag} = 6'($urandom);
      rd(vhap_pkg::P_MISC_WR_ST1, {crt_irq, 2'b00, switch_sense, 4'h0},
         8'hFF);
      rd(vhap_pkg::P_ST2_M, {4'h0, vretrace, 2'b00, disp_inactive},
         8'hCF);
      rd(vhap_pkg::P_ST2_C, 8'hFF, 8'hFF);
      for (int em = 0; em < 2; em++) begin
         wr(vhap_pkg::P_MISC_WR_ST1, 8'(em));
         b = em ? vhap_pkg::P_CRT_IDX_C : vhap_pkg::P_CRT_IDX_M;
         o = em ? vhap_pkg::P_CRT_DAT_M : vhap_pkg::P_CRT_DAT_C;
         i = 8'($urandom_range(24));
         e = 8'($urandom);
         idx(b, i, e);
         wr(o, ~e);
         rd(b, i, 8'hFF);
         rd(b + 16'h0001, e, 8'hFF);
         rd(o, 8'hFF, 8'hFF);
         idx(b, 8'd25, e);
         rd(b + 16'h0001, 8'h00, 8'hFF);
      end
      for (int g = 0; g < 2; g++) begin
         b = g ? vhap_pkg::P_GFX_IDX : vhap_pkg::P_SEQ_IDX;
         k = g ? 8'd9 : 8'd5;
         e = 8'($urandom);
         idx(b, k - 8'd1, e);
         rd(b + 16'h0001, e, 8'hFF);
         idx(b, k, ~e);
         rd(b + 16'h0001, 8'h00, 8'hFF);
      end
      i = 8'($urandom_range(20));
      e = 8'($urandom);
      wr(vhap_pkg::P_ATTR_IDX, 8'h13);
      rd(vhap_pkg::P_ST2_C, {4'h0, vretrace, 2'b00, disp_inactive},
         8'hCF);
      idx(vhap_pkg::P_ATTR_IDX - 16'h0001, 8'h00, i);
      wr(vhap_pkg::P_ATTR_IDX, e);
      rd(vhap_pkg::P_ATTR_RD, e, 8'hFF);
      rd(vhap_pkg::P_ATTR_IDX, i, 8'h3F);
      for (int p = 0; p < 3; p++) d[p] = 8'($urandom) & 8'h3F;
      i = 8'($urandom);
      wr(vhap_pkg::P_PAL_ADDR, i);
      for (int p = 0; p < 3; p++) wr(vhap_pkg::P_PAL_DATA, d[p]);
      wr(vhap_pkg::P_PAL_ADDR_ALT, i);
      rd(vhap_pkg::P_PAL_ADDR_ALT, 8'h03, 8'hFF);
      rd(vhap_pkg::P_PAL_ADDR, i, 8'hFF);
      for (int p = 0; p < 3; p++) rd(vhap_pkg::P_PAL_DATA, d[p], 8'h3F);
      rd(vhap_pkg::P_PAL_ADDR, i + 8'h01, 8'hFF);
      wr(vhap_pkg::P_MISC_WR_ST1, 8'h03);
      idx(vhap_pkg::P_SEQ_IDX, vhap_pkg::SEQ_MEM_MODE, 8'h00);
      idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_MODE, 8'h00);
      idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_MISC, 8'h00);
      a = 20'hA0000 + 20'($urandom_range(16'hFFFE));
      for (int p = 0; p < 4; p++) begin
         d[p] = 8'($urandom);
         idx(vhap_pkg::P_SEQ_IDX, vhap_pkg::SEQ_MAP_MASK, 8'h01 << p);
         i_vhap_host_model.mem_cycle(1'b1, a, d[p]);
      end
      for (int p = 0; p < 4; p++) begin
         idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_RMAP, 8'(p));
         mrd(a, d[p]);
      end
      idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_MODE, 8'h08);
      for (int n = 0; n < 2; n++) begin
         c = n ? 8'($urandom) : 8'h0F;
         k = 8'($urandom);
         idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_DC, c);
         idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_CMP, k);
         e = 8'hFF;
         for (int t = 0; t < 8; t++)
            for (int j = 0; j < 4; j++)
               if (c[j] && d[j][t] != k[j]) e[t] = 1'b0;
         mrd(a, e);
      end
      idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_MODE, 8'h10);
      idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_MISC, 8'h08);
      idx(vhap_pkg::P_SEQ_IDX, vhap_pkg::SEQ_MAP_MASK, 8'h0F);
      d[0] = 8'($urandom);
      d[1] = 8'($urandom);
      i_vhap_host_model.mem_cycle(1'b1, 20'hB0000, d[0]);
      i_vhap_host_model.mem_cycle(1'b1, 20'hB0001, d[1]);
      mrd(20'hB0000, d[0]);
      mrd(20'hB0001, d[1]);
      mrd(20'hA0000, 8'hFF);
      idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_MODE, 8'h00);
      for (int p = 0; p < 2; p++) begin
         idx(vhap_pkg::P_GFX_IDX, vhap_pkg::GFX_RMAP, 8'(p));
         mrd(20'hB0000, d[p]);
      end
      repeat (5) @(negedge ref_clk);
      wrap_up();
   end
endmodule : test_video_host_access_port
